// File: verilog/mps_pkg.sv
// shared constants and types of the modbus poll sequencer
package mps_pkg;

  // ----------------------------------------------------------------
  // clock and serial timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD_BPS; // rounds down to 4166
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int TMO_MS_DEF = 1000; // default reply timeout
  localparam int PAUSE_MS_DEF = 100; // default pause between commands
  localparam int CHECKIN_MS_DEF = 60000; // default check-in period

  // ----------------------------------------------------------------
  // program table limits
  // ----------------------------------------------------------------
  localparam int MAX_STEPS = 34;
  localparam logic [7:0] CNT_MAX = 8'h19; // 25 registers
  localparam logic [7:0] CNT_MAX_ENRON = 8'h0C; // 12 registers
  localparam logic [7:0] COIL_MAX = 8'h01;

  // ----------------------------------------------------------------
  // function codes and frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DIN = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INP = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam int EXC_BIT = 7; // set in the function byte of an exception reply
  localparam logic [2:0] REQ_LAST = 3'h7; // request is 8 bytes
  localparam logic [7:0] EXC_LEN = 8'h05;
  localparam logic [7:0] COIL_RSP_LEN = 8'h06;
  localparam logic [7:0] WR_RSP_LEN = 8'h08;
  localparam logic [7:0] REG_RSP_OVH = 8'h05;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] addr;
    logic [7:0] count;
  } mps_step_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_SEND = 5'h04,
    ST_WAIT = 5'h08,
    ST_PAUSE = 5'h10
  } mps_state_t;

endpackage

// File: verilog/mps_uart.sv
// half-duplex 8N1 serial transceiver with rs-485 driver enable
`timescale 1ns/1ps
module mps_uart #(
  parameter int CLKS_PER_BIT = mps_pkg::BIT_CYC
)(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, low
  input wire logic ce, // clock enable
  input wire logic tx_valid, // byte offered
  input wire logic [7:0] tx_data, // byte to send
  output logic tx_ready, // transmitter idle
  input wire logic rx_pin, // raw receive pin
  output logic rx_valid, // one-cycle byte strobe
  output logic [7:0] rx_data, // received byte
  output logic tx_pin, // transmit pin
  output logic de // driver enable
);

  localparam int CW = $clog2(CLKS_PER_BIT + 1);

  generate
    if (CLKS_PER_BIT < 4) begin : g_chk
      $error("CLKS_PER_BIT too small");
    end
  endgenerate

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic [8:0] tsh_r, tsh_nxt;
  logic [3:0] tbit_r, tbit_nxt;
  logic [CW-1:0] tcnt_r, tcnt_nxt;
  logic tbsy_r, tbsy_nxt, tpin_r, tpin_nxt, de_r, de_nxt;

  // one 8N1 character
  // start bit goes out at once; stop bit ends with the enable drop
  always_comb begin
    tsh_nxt = tsh_r;
    tbit_nxt = tbit_r;
    tcnt_nxt = tcnt_r;
    tbsy_nxt = tbsy_r;
    tpin_nxt = tpin_r;
    de_nxt = de_r;
    if (!tbsy_r) begin
      if (tx_valid) begin
        tsh_nxt = {1'b1, tx_data};
        tbit_nxt = 4'h0;
        tcnt_nxt = '0;
        tbsy_nxt = 1'b1;
        tpin_nxt = 1'b0;
        de_nxt = 1'b1;
      end
    end else if (tcnt_r == CW'(CLKS_PER_BIT - 1)) begin
      tcnt_nxt = '0;
      if (tbit_r == 4'h9) begin
        tbsy_nxt = 1'b0;
        de_nxt = 1'b0;
        tpin_nxt = 1'b1;
      end else begin
        tpin_nxt = tsh_r[0];
        tsh_nxt = {1'b1, tsh_r[8:1]};
        tbit_nxt = tbit_r + 4'h1;
      end
    end else begin
      tcnt_nxt = tcnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsh_r <= '1;
      tbit_r <= 4'h0;
      tcnt_r <= '0;
      tbsy_r <= 1'b0;
      tpin_r <= 1'b1;
      de_r <= 1'b0;
    end else if (ce) begin
      tsh_r <= tsh_nxt;
      tbit_r <= tbit_nxt;
      tcnt_r <= tcnt_nxt;
      tbsy_r <= tbsy_nxt;
      tpin_r <= tpin_nxt;
      de_r <= de_nxt;
    end
  end

  assign tx_ready = !tbsy_r;
  assign tx_pin = tpin_r;
  assign de = de_r;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic s1_r, s2_r;
  logic [7:0] rsh_r, rsh_nxt;
  logic [3:0] rbit_r, rbit_nxt;
  logic [CW-1:0] rcnt_r, rcnt_nxt;
  logic rbsy_r, rbsy_nxt, rval_r, rval_nxt;

  // own echo is ignored while driving, the bus is half duplex
  always_comb begin
    rsh_nxt = rsh_r;
    rbit_nxt = rbit_r;
    rcnt_nxt = rcnt_r;
    rbsy_nxt = rbsy_r;
    rval_nxt = 1'b0;
    if (!rbsy_r) begin
      if (!de_r && !s2_r) begin
        rbsy_nxt = 1'b1;
        rbit_nxt = 4'h0;
        rcnt_nxt = CW'(CLKS_PER_BIT / 2);
      end
    end else if (rcnt_r != '0) begin
      rcnt_nxt = rcnt_r - CW'(1);
    end else begin
      rcnt_nxt = CW'(CLKS_PER_BIT - 1);
      rbit_nxt = rbit_r + 4'h1;
      if (rbit_r == 4'h0) begin
        rbsy_nxt = !s2_r; // glitch, not a start bit
      end else if (rbit_r == 4'h9) begin
        rbsy_nxt = 1'b0;
        rval_nxt = s2_r; // framing error drops the byte
      end else begin
        rsh_nxt = {s2_r, rsh_r[7:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      rsh_r <= 8'h00;
      rbit_r <= 4'h0;
      rcnt_r <= '0;
      rbsy_r <= 1'b0;
      rval_r <= 1'b0;
    end else if (ce) begin
      s1_r <= rx_pin;
      s2_r <= s1_r;
      rsh_r <= rsh_nxt;
      rbit_r <= rbit_nxt;
      rcnt_r <= rcnt_nxt;
      rbsy_r <= rbsy_nxt;
      rval_r <= rval_nxt;
    end
  end

  assign rx_valid = rval_r;
  assign rx_data = rsh_r;

endmodule

// File: verilog/mps_poll_seq.sv
// modbus poll sequencer: runs the stored program steps on each check-in
// ------------------------------------------------------------------
// Functional notes
// - each check-in period the program steps run and reply bytes go upstream.
// - the serial link runs 9600 baud, 8 data bits, no parity, one stop bit.
// - a command with no complete reply within the timeout is abandoned.
// - a configurable pause, 100 ms by default, separates successive commands.
// - up to 34 program steps are stored and run in table order.
// - a step holds slave id, function code, start address and count.
// - function codes 0x01 to 0x05 are accepted, others are skipped.
// - coil and discrete-input reads are limited to one coil.
// - the count is limited to 25 registers, or 12 in the Enron variant.
// - the addressing offset, zero or one, is subtracted from the address.
// ------------------------------------------------------------------
`timescale 1ns/1ps
module mps_poll_seq #(
  parameter int CLKS_PER_BIT = mps_pkg::BIT_CYC,
  parameter int CLKS_PER_MS = mps_pkg::MS_CYC
)(
  input wire logic sys_clk, // 40 MHz clock
  input wire logic nrst, // async reset, low
  input wire logic ce, // clock enable
  input wire logic cfg_one_based, // subtract one from addresses
  input wire logic cfg_enron, // enron register limit
  input wire logic [15:0] cfg_timeout_ms, // reply timeout
  input wire logic [15:0] cfg_pause_ms, // pause between commands
  input wire logic [31:0] cfg_checkin_ms, // check-in period
  input wire logic [5:0] cfg_num_steps, // used table entries
  input wire logic step_we, // table write strobe
  input wire logic [5:0] step_widx, // table index
  input wire logic [7:0] step_wslave, // slave id
  input wire logic [7:0] step_wfunc, // function code
  input wire logic [15:0] step_waddr, // entered address
  input wire logic [7:0] step_wcount, // register count
  input wire logic rs485_rx, // receive pin
  output logic rs485_tx, // transmit pin
  output logic rs485_de, // driver enable
  output logic rsp_valid, // reply byte strobe
  output logic [7:0] rsp_data, // reply byte
  output logic [5:0] rsp_step, // step of that byte
  output logic rsp_first, // first byte of a reply
  output logic step_done, // reply complete
  output logic step_timeout, // reply timed out
  output logic step_skip, // illegal step skipped
  output logic cycle_done, // program finished
  output logic busy // program running
);

  generate
    if (CLKS_PER_MS < 1) begin : g_chk
      $error("CLKS_PER_MS must be positive");
    end
  endgenerate

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic fc_ok(input logic [7:0] f);
    return f >= mps_pkg::FC_RD_COIL && f <= mps_pkg::FC_WR_COIL;
  endfunction

  function automatic logic [7:0] cnt_limit(input logic [7:0] f, input logic enron);
    if (f == mps_pkg::FC_RD_HOLD || f == mps_pkg::FC_RD_INP) begin
      return enron ? mps_pkg::CNT_MAX_ENRON : mps_pkg::CNT_MAX;
    end
    return mps_pkg::COIL_MAX;
  endfunction

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ mps_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // reset release and program table
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  mps_pkg::mps_step_t mem_r [mps_pkg::MAX_STEPS];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < mps_pkg::MAX_STEPS; i++) begin
        mem_r[i] <= '0; // function 0 reads as an empty step
      end
    end else if (ce && step_we && step_widx < 6'(mps_pkg::MAX_STEPS)) begin
      mem_r[step_widx] <= '{step_wslave, step_wfunc, step_waddr, step_wcount};
    end
  end

  // ----------------------------------------------------------------
  // check-in period timer
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_r, ms_cnt_nxt, per_ms_r, per_ms_nxt;
  logic pend_r, pend_nxt, ms_tick, per_hit, take;

  // period tick; a tick during a run is held, not lost
  always_comb begin
    ms_tick = ms_cnt_r == 32'(CLKS_PER_MS - 1);
    ms_cnt_nxt = ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
    per_hit = ms_tick && (per_ms_r + 32'h1 >= cfg_checkin_ms);
    per_ms_nxt = per_hit ? 32'h0 : (ms_tick ? per_ms_r + 32'h1 : per_ms_r);
    pend_nxt = per_hit || (pend_r && !take);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 32'h0;
      per_ms_r <= 32'h0;
      pend_r <= 1'b0;
    end else if (ce) begin
      ms_cnt_r <= ms_cnt_nxt;
      per_ms_r <= per_ms_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // step sequencer
  // ----------------------------------------------------------------
  mps_pkg::mps_state_t state_r, state_nxt;
  mps_pkg::mps_step_t ld;
  logic [5:0] step_r, step_nxt, num_eff;
  logic [2:0] txi_r, txi_nxt;
  logic [15:0] crc_r, crc_nxt, val;
  logic [31:0] gap_r, gap_nxt, gap_lim;
  logic [7:0] rxc_r, rxc_nxt, exp_r, exp_nxt, exp_eff, lim, tx_byte;
  logic [7:0] slv_r, slv_nxt, fc_r, fc_nxt, cnt_r, cnt_nxt;
  logic [15:0] adr_r, adr_nxt;
  logic rv_nxt, rf_nxt, dn_nxt, to_nxt, sk_nxt, cd_nxt, adv, adv_pause, gap_done;
  logic [7:0] rd_nxt;
  logic tx_ready, rx_valid;
  logic [7:0] rx_data;

  mps_uart #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_uart (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .tx_valid(state_r == mps_pkg::ST_SEND),
    .tx_data(tx_byte),
    .tx_ready(tx_ready),
    .rx_pin(rs485_rx),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_pin(rs485_tx),
    .de(rs485_de)
  );

  assign ld = mem_r[step_r];
  assign num_eff = cfg_num_steps > 6'(mps_pkg::MAX_STEPS) ? 6'(mps_pkg::MAX_STEPS) : cfg_num_steps;
  // one timer serves both, measured in cycles of the ms figure
  assign gap_lim = 32'(state_r == mps_pkg::ST_PAUSE ? cfg_pause_ms : cfg_timeout_ms) * 32'(CLKS_PER_MS);
  assign gap_done = gap_r + 32'h1 >= gap_lim;
  assign lim = cnt_limit(ld.func, cfg_enron);
  assign take = state_r == mps_pkg::ST_IDLE;
  // a write carries the coil state in the count field
  assign val = fc_r == mps_pkg::FC_WR_COIL ? (cnt_r != 8'h00 ? mps_pkg::COIL_ON : 16'h0000) : {8'h00, cnt_r};
  assign exp_eff = (rxc_r == 8'h01 && rx_data[mps_pkg::EXC_BIT]) ? mps_pkg::EXC_LEN : exp_r;

  // request byte order: id, function, address, count or value, crc low first
  always_comb begin
    unique case (txi_r)
      3'h0: tx_byte = slv_r;
      3'h1: tx_byte = fc_r;
      3'h2: tx_byte = adr_r[15:8];
      3'h3: tx_byte = adr_r[7:0];
      3'h4: tx_byte = val[15:8];
      3'h5: tx_byte = val[7:0];
      3'h6: tx_byte = crc_r[7:0];
      3'h7: tx_byte = crc_r[15:8];
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    txi_nxt = txi_r;
    crc_nxt = crc_r;
    rxc_nxt = rxc_r;
    exp_nxt = exp_r;
    slv_nxt = slv_r;
    fc_nxt = fc_r;
    adr_nxt = adr_r;
    cnt_nxt = cnt_r;
    rv_nxt = 1'b0;
    rd_nxt = rsp_data;
    rf_nxt = 1'b0;
    dn_nxt = 1'b0;
    to_nxt = 1'b0;
    sk_nxt = 1'b0;
    cd_nxt = 1'b0;
    adv = 1'b0;
    adv_pause = 1'b1;
    unique case (state_r)
      mps_pkg::ST_IDLE: begin
        if (pend_r) begin
          step_nxt = 6'h00;
          if (num_eff == 6'h00) begin
            cd_nxt = 1'b1;
          end else begin
            state_nxt = mps_pkg::ST_LOAD;
          end
        end
      end
      mps_pkg::ST_LOAD: begin
        // unknown function codes are skipped without bus traffic
        if (!fc_ok(ld.func)) begin
          sk_nxt = 1'b1;
          adv = 1'b1;
          adv_pause = 1'b0;
        end else begin
          slv_nxt = ld.slave;
          fc_nxt = ld.func;
          adr_nxt = ld.addr - {15'h0000, cfg_one_based};
          cnt_nxt = (ld.count > lim && ld.func != mps_pkg::FC_WR_COIL) ? lim : ld.count;
          crc_nxt = mps_pkg::CRC_INIT;
          txi_nxt = 3'h0;
          state_nxt = mps_pkg::ST_SEND;
        end
      end
      mps_pkg::ST_SEND: begin
        if (tx_ready) begin
          crc_nxt = txi_r < 3'h6 ? crc_upd(crc_r, tx_byte) : crc_r;
          txi_nxt = txi_r + 3'h1;
          if (txi_r == mps_pkg::REQ_LAST) begin
            rxc_nxt = 8'h00;
            if (fc_r == mps_pkg::FC_WR_COIL) begin
              exp_nxt = mps_pkg::WR_RSP_LEN;
            end else if (fc_r <= mps_pkg::FC_RD_DIN) begin
              exp_nxt = mps_pkg::COIL_RSP_LEN;
            end else begin
              exp_nxt = mps_pkg::REG_RSP_OVH + {cnt_r[6:0], 1'b0};
            end
            state_nxt = mps_pkg::ST_WAIT;
          end
        end
      end
      mps_pkg::ST_WAIT: begin
        // reply bytes are forwarded as they arrive
        if (rx_valid) begin
          rv_nxt = 1'b1;
          rd_nxt = rx_data;
          rf_nxt = rxc_r == 8'h00;
          rxc_nxt = rxc_r + 8'h01;
          exp_nxt = exp_eff;
          if (rxc_r + 8'h01 >= exp_eff) begin
            dn_nxt = 1'b1;
            adv = 1'b1;
          end
        // timeout counts once the request has left the wire
        end else if (gap_done && tx_ready) begin
          to_nxt = 1'b1;
          adv = 1'b1;
        end
      end
      mps_pkg::ST_PAUSE: begin
        if (gap_done) begin
          state_nxt = mps_pkg::ST_LOAD;
        end
      end
    endcase
    // table order, then idle after the last step
    if (adv) begin
      if (7'(step_r) + 7'h01 >= 7'(num_eff)) begin
        state_nxt = mps_pkg::ST_IDLE;
        step_nxt = 6'h00;
        cd_nxt = 1'b1;
      end else begin
        step_nxt = step_r + 6'h01;
        state_nxt = adv_pause ? mps_pkg::ST_PAUSE : mps_pkg::ST_LOAD;
      end
    end
    gap_nxt = (state_nxt != state_r || (state_r == mps_pkg::ST_WAIT && !tx_ready)) ? 32'h0 : gap_r + 32'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mps_pkg::ST_IDLE;
      step_r <= 6'h00;
      txi_r <= 3'h0;
      crc_r <= mps_pkg::CRC_INIT;
      gap_r <= 32'h0;
      rxc_r <= 8'h00;
      exp_r <= 8'h00;
      slv_r <= 8'h00;
      fc_r <= 8'h00;
      adr_r <= 16'h0000;
      cnt_r <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_step <= 6'h00;
      rsp_first <= 1'b0;
      step_done <= 1'b0;
      step_timeout <= 1'b0;
      step_skip <= 1'b0;
      cycle_done <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      txi_r <= txi_nxt;
      crc_r <= crc_nxt;
      gap_r <= gap_nxt;
      rxc_r <= rxc_nxt;
      exp_r <= exp_nxt;
      slv_r <= slv_nxt;
      fc_r <= fc_nxt;
      adr_r <= adr_nxt;
      cnt_r <= cnt_nxt;
      rsp_valid <= rv_nxt;
      rsp_data <= rd_nxt;
      rsp_step <= step_r;
      rsp_first <= rf_nxt;
      step_done <= dn_nxt;
      step_timeout <= to_nxt;
      step_skip <= sk_nxt;
      cycle_done <= cd_nxt;
      busy <= state_nxt != mps_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_checkin;
    state_r == mps_pkg::ST_IDLE && pend_r && ce && num_eff != 6'h00 |=> state_r == mps_pkg::ST_LOAD && step_r == 6'h00;
  endproperty
  a_checkin: assert property (p_checkin) else $error("check-in did not start step 0");

  property p_start_bit;
    $rose(rs485_de) && ce |-> !rs485_tx [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");

  property p_tmo;
    step_timeout |-> $past(state_r) == mps_pkg::ST_WAIT && $past(gap_r) + 32'h1 >= $past(gap_lim);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout before limit");

  property p_pause;
    $past(state_r) == mps_pkg::ST_PAUSE && state_r == mps_pkg::ST_LOAD |-> $past(gap_done);
  endproperty
  a_pause: assert property (p_pause) else $error("pause cut short");

  property p_steps;
    state_r != mps_pkg::ST_IDLE |-> step_r < 6'(mps_pkg::MAX_STEPS);
  endproperty
  a_steps: assert property (p_steps) else $error("step index out of table");

  property p_frame;
    $past(state_r) == mps_pkg::ST_SEND && state_r == mps_pkg::ST_WAIT |-> $past(txi_r) == mps_pkg::REQ_LAST;
  endproperty
  a_frame: assert property (p_frame) else $error("request not 8 bytes");

  property p_fc;
    state_r == mps_pkg::ST_SEND |-> fc_ok(fc_r);
  endproperty
  a_fc: assert property (p_fc) else $error("illegal function sent");

  property p_coil;
    state_r == mps_pkg::ST_SEND && fc_r <= mps_pkg::FC_RD_DIN |-> cnt_r <= mps_pkg::COIL_MAX;
  endproperty
  a_coil: assert property (p_coil) else $error("coil read over one");

  property p_cnt;
    state_r == mps_pkg::ST_SEND && fc_r != mps_pkg::FC_WR_COIL |-> cnt_r <= mps_pkg::CNT_MAX;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count over limit");

  property p_addr;
    state_r == mps_pkg::ST_SEND && $past(state_r) == mps_pkg::ST_LOAD |->
      adr_r == $past(ld.addr) - {15'h0000, $past(cfg_one_based)};
  endproperty
  a_addr: assert property (p_addr) else $error("address offset wrong");

  property p_idle;
    cycle_done |-> state_r == mps_pkg::ST_IDLE && step_r == 6'h00 && !busy;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after program");

  c_cycle: cover property (cycle_done);
  c_tmo: cover property (step_timeout);
  c_done: cover property (step_done);
  c_skip: cover property (step_skip);

endmodule

// File: test/mps_slave_model.sv
// serial slave model answering each request of the poll sequencer except those to mute_id
`timescale 1ns/1ps
module mps_slave_model #(
  parameter int B = 8
)(
  input wire logic clk, // system clock
  input wire logic tx, // request line
  input wire logic [7:0] mute_id, // slave that never answers
  input wire logic [7:0] exc_id, // slave that refuses
  output logic rx, // reply line, biased high when idle
  output logic [47:0] req // last request without crc
);
  logic [7:0] b [8];
  logic [7:0] n;

  // one character: start low, lsb first, stop high
  task automatic put(input logic [7:0] d);
    #1;
    for (int k = 0; k < 10; k++) begin
      rx = (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : d[k-1];
      repeat (B) @(posedge clk);
    end
  endtask

  // sample mid-bit, answer once the driver has turned round
  initial begin
    rx = 1'b1;
    req = '0;
    forever begin
      for (int i = 0; i < 8; i++) begin
        @(negedge tx);
        repeat (B + B / 2) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
          b[i][k] = tx;
          repeat (B) @(posedge clk);
        end
      end
      req = {b[0], b[1], b[2], b[3], b[4], b[5]};
      n = (b[1] == 8'h05) ? 8'h08 : (b[1] < 8'h03) ? 8'h06 : 8'h05 + {b[5][6:0], 1'b0};
      if (b[0] == exc_id) n = 8'h05;
      repeat (3 * B) @(posedge clk);
      // a muted slave leaves the line idle so the sequencer must give up
      if (b[0] != mute_id)
        for (int i = 0; i < n; i++) put((i == 1 && b[0] == exc_id) ? b[1] | 8'h80 : (i == 0) ? b[0] : 8'(i));
    end
  end
endmodule

// File: test/mps_poll_seq_test.sv
// self-checking bench of the poll sequencer against a serial slave model
`timescale 1ns/1ps
module mps_poll_seq_test;
  localparam int MS = 16;
  localparam int FZ = 20;
  logic sys_clk = 1'b0, nrst = 1'b0, ob = 1'b0, en = 1'b0, we = 1'b0, ce = 1'b1;
  logic [15:0] pz = 16'h0003, wa = 16'h0000;
  logic [7:0] ws = 8'h00, wf = 8'h00, wc = 8'h00, rd;
  logic [5:0] wi = 6'h00, rstep, ns = 6'h06;
  logic tx, de, rx, rv, rf, sd, st, sk, cd, busy;
  logic [47:0] req;
  logic [47:0] ex [6];
  logic [7:0] ln [6];
  logic [2:0] ee [6];
  int fail_count = 0, checked = 0, seed = 32'h0612e38b, cyc = 0, bs = 0;

  mps_poll_seq #(.CLKS_PER_BIT(8), .CLKS_PER_MS(MS)) u_mps_poll_seq (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .cfg_one_based(ob), .cfg_enron(en), .cfg_timeout_ms(16'h012C), .cfg_pause_ms(pz),
    .cfg_checkin_ms(32'h000003E8), .cfg_num_steps(ns), .step_we(we), .step_widx(wi), .step_wslave(ws),
    .step_wfunc(wf), .step_waddr(wa), .step_wcount(wc), .rs485_rx(rx), .rs485_tx(tx), .rs485_de(de),
    .rsp_valid(rv), .rsp_data(rd), .rsp_step(rstep), .rsp_first(rf), .step_done(sd), .step_timeout(st),
    .step_skip(sk), .cycle_done(cd), .busy(busy));
  mps_slave_model #(.B(8)) u_mps_slave_model (.clk(sys_clk), .tx(tx), .mute_id(8'hF1), .exc_id(8'hF2),
    .rx(rx), .req(req));

  // ----------------------------------------------------------------
  // clock, cycle count, tasks
  // ----------------------------------------------------------------
  initial forever #12.5 sys_clk = ~sys_clk;
  // cycle count for period checks
  always @(negedge sys_clk) cyc <= cyc + 1;

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] rs();
    return 8'h01 + 8'($random(seed) & 32'h7F);
  endfunction

  // write one entry and work out its request
  task automatic put_step(input int i, input logic [7:0] s, input logic [7:0] f, input logic [7:0] c);
    logic [7:0] m;
    @(negedge sys_clk);
    wa = 16'($random(seed));
    m = (f < 8'h03) ? mps_pkg::COIL_MAX : en ? mps_pkg::CNT_MAX_ENRON : mps_pkg::CNT_MAX;
    if (c < m) m = c;
    ex[i] = {s, f, wa - 16'(ob), (f == 8'h05) ? ((c != 8'h00) ? 16'hFF00 : 16'h0000) : {8'h00, m}};
    ln[i] = (s == 8'hF2) ? 8'h05 : (f == 8'h05) ? 8'h08 : (f < 8'h03) ? 8'h06 : 8'h05 + 8'h02 * m;
    ee[i] = (f == 8'h00 || f > 8'h05) ? 3'h1 : (s == 8'hF1) ? 3'h2 : 3'h4;
    {we, wi, ws, wf, wc} = {1'b1, 6'(i), s, f, c};
    @(negedge sys_clk);
    we = 1'b0;
  endtask

  // follow one program run step by step; the pause is seen at the next driver rise
  task automatic run_prog();
    int t, nb, lo, gap, gp;
    logic dq;
    nb = 0;
    lo = 0;
    gap = 0;
    gp = 0;
    dq = 1'b0;
    for (int i = 0; i < 6; i++) begin
      t = 0;
      do begin
        @(negedge sys_clk);
        t++;
        gap++;
        lo = de ? 0 : lo + 1;
        if (de && !dq && gp != 0) check(48'(gap >= pz * MS && gap <= pz * MS + 8), 48'h1);
        if (de) gp = 0;
        dq = de;
        if (rv) nb = rf ? 1 : nb + 1;
        if (rv && rf) check(48'(rd), 48'(ex[i][47:40]));
      end while (!(sd || st || sk) && t < 20000);
      check(48'({sd, st, sk}), 48'(ee[i]));
      if (sd) check(48'(nb), 48'(ln[i]));
      if (sd) check(48'(rstep), 48'(i));
      if (sd || st) check(req, ex[i]);
      if (st) check(48'(lo >= 300 * MS && lo <= 300 * MS + 4), 48'h1);
      if (sd || st) begin
        gap = 0;
        gp = 1;
      end
    end
    // cycle_done comes with the last step's pulse, so look before waiting
    t = 0;
    while (!cd && t < 8) begin
      @(negedge sys_clk);
      t++;
    end
    check(48'({cd, busy}), 48'h2);
  endtask

  // ----------------------------------------------------------------
  // main sequence: two runs with offset, enron and pause changed
  // ----------------------------------------------------------------
  initial begin
    int t;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int r = 0; r < 2; r++) begin
      {ob, en} = (r == 0) ? 2'h0 : 2'h3;
      pz = (r == 0) ? 16'h0003 : 16'h0000;
      put_step(0, rs(), 8'h05, 8'(r));
      put_step(1, rs(), 8'h01 + 8'(r), 8'h09);
      put_step(2, rs(), (r == 0) ? 8'h07 : 8'h00, rs());
      put_step(3, rs(), 8'h03 + 8'(r), 8'h1E);
      // a float asked for as two registers
      put_step(4, 8'hF1, 8'h04, 8'h02);
      put_step(5, 8'hF2, 8'h04, 8'h03);
      // clock enable low must hold the check-in timer, so the period stretches
      if (r > 0) begin
        ce = 1'b0;
        repeat (FZ) @(negedge sys_clk);
        ce = 1'b1;
      end
      t = 0;
      while (!busy && t < 40000) begin
        @(negedge sys_clk);
        t++;
      end
      if (r > 0) check(48'(cyc - bs >= 1000 * MS + FZ - 2 && cyc - bs <= 1000 * MS + FZ + 2), 48'h1);
      bs = cyc;
      run_prog();
    end
    complete_run;
  end

  // watchdog against a hung sequencer
  initial begin
    #(25 * 60000);
    fail_count++;
    complete_run;
  end
endmodule
